//--- hw/rps_pkg.sv
// Package for the RTC power and reset sequencer: constants, states and carriers
package rps_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ          = 20_000_000;
    localparam int SCAN_SLOW_SEC   = 1;   // Scan period when period select is 0
    localparam int SCAN_LONG_SEC   = 16;  // Scan period when period select is 1
    localparam int SCAN_SLOW_CYC   = CLK_HZ * SCAN_SLOW_SEC;
    localparam int SCAN_LONG_CYC   = CLK_HZ * SCAN_LONG_SEC;
    localparam int FAST_SCAN_CYC   = 64;  // Fast scan interval during power-up
    localparam int WDOG_PERIODS    = 2;   // Deadlock budget in monitoring periods
    localparam int CNT_W           = 32;

    // ----------------------------------------------------------------
    // Values
    // ----------------------------------------------------------------
    localparam logic [7:0] TEMP_FROZEN = 8'h00;
    localparam logic [7:0] TEMP_RESET  = 8'h00;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RPS_HOLD,
        RPS_LOAD,
        RPS_WAIT_OSC,
        RPS_FAST_SCAN,
        RPS_EE_LOAD,
        RPS_TEMP,
        RPS_RUN
    } rps_state_type;

    // Status flags shown to the host
    typedef struct packed {
        logic powerOnFlag;
        logic systemResetFlag;
        logic selfRecoveryIrqFlag;
        logic lowVoltageUpperFlag;
        logic lowVoltageLowerFlag;
    } rps_flags_type;

    // Flag clear strobes from the host, one per flag
    typedef struct packed {
        logic powerOnFlag;
        logic systemResetFlag;
        logic selfRecoveryIrqFlag;
        logic lowVoltageUpperFlag;
        logic lowVoltageLowerFlag;
    } rps_clear_type;

endpackage : rps_pkg

//--- hw/rps_sequencer.sv
// Power-up, supply switchover, low-voltage and reset sequencer of the RTC
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Trickle charge on only with resistors selected and never on backup supply.
// - Route the higher of main and backup supply inside; show the source.
// - On backup, disable serial interface and clock output; interrupt stays alive.
// - Hold in reset until supply threshold, then load all reset values.
// - Set power-on flag after power-on reset; cleared only by writing 0.
// - Fast scan once oscillator runs; above lower threshold stop it, enable EEPROM.
// - After EEPROM enable, load configuration and clear both low-voltage flags.
// - With thermometer enabled, measure and compute compensation before running.
// - After fast scan, sample supply once per monitoring period.
// - A check below a threshold sets its flag and disables dependent functions.
// - Uncleared low-voltage flags freeze temperature at 00h if no reading is valid; that or the lower flag stops compensation.
// - Below upper threshold, hold last temperature; compensation keeps using it.
// - Reset comes only from power-on, software command or self-recovery.
// - Software reset command in run state resets system and sets system-reset flag.
// - After any reset, self-recovery enable is 1 and its interrupt enable 0.
// - Deadlock with self-recovery on, in run state, resets system, sets both flags.
// - Self-recovery interrupt only when its interrupt enable is 1.
// - Deadlock counter restarted by control logic; timeout triggers system reset.
// - Self-recovery acts within two monitoring periods of deadlock onset.
// - Period select 0 gives a one-second monitoring interval.
module rps_sequencer
    import rps_pkg::*;
#(
    parameter int SLOW_CYC = rps_pkg::SCAN_SLOW_CYC,
    parameter int LONG_CYC = rps_pkg::SCAN_LONG_CYC,
    parameter int FAST_CYC = rps_pkg::FAST_SCAN_CYC
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Analog comparator levels (asynchronous)
    input  wire logic          mainAboveBackup,
    input  wire logic          supplyAboveThreshold,
    input  wire logic          oscRunning,
    input  wire logic          aboveLowerThreshold,
    input  wire logic          aboveUpperThreshold,
    // Configuration from the EEPROM control page
    input  wire logic          eeConfigValid,
    input  wire logic [3:0]    chargeResistorSelect,
    input  wire logic          thermometerEnable,
    input  wire logic          thermometerPeriodSelect,
    // Thermometer and compensation unit
    input  wire logic          tempDone,
    input  wire logic [7:0]    tempMeasured,
    input  wire logic          compDone,
    // Host commands (one-cycle pulses)
    input  wire logic          softwareResetCommand,
    input  wire rps_clear_type flagClear,
    input  wire logic          setSelfRecoveryEnable,
    input  wire logic          setSelfRecoveryIrqEnable,
    input  wire logic          selfRecoveryEnableValue,
    input  wire logic          selfRecoveryIrqEnableValue,
    // Deadlock counter restart from the control logic
    input  wire logic          controlAlive,
    // Supply routing
    output logic               internalSupplyFromBackup,
    output logic               trickleChargeEnable,
    output logic               serialInterfaceEnable,
    output logic               clockOutputEnable,
    output logic               interruptOutputEnable,
    // Sequencing outputs
    output logic               registerReload,
    output logic               eeReadEnable,
    output logic               fastScanActive,
    output logic               tempStart,
    output logic               compStart,
    output logic               compensationActive,
    output logic               fullyFunctional,
    // Status
    output logic [7:0]         temperature,
    output rps_flags_type      flags,
    output logic               selfRecoveryEnable,
    output logic               selfRecoveryIrqEnable,
    output logic               selfRecoveryIrq
);

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    logic [4:0] rawIn;
    logic [4:0] syncIn;
    logic       mainHigher;
    logic       supplyOk;
    logic       oscOk;
    logic       aboveLower;
    logic       aboveUpper;

    assign rawIn = {mainAboveBackup, supplyAboveThreshold, oscRunning,
                    aboveLowerThreshold, aboveUpperThreshold};

    rps_sync #(.WIDTH(5)) uSync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (rawIn),
        .syncOut (syncIn)
    );

    assign {mainHigher, supplyOk, oscOk, aboveLower, aboveUpper} = syncIn;

    // ----------------------------------------------------------------
    // Supply routing and gating
    // ----------------------------------------------------------------
    logic onBackup;

    // Higher supply wins; backup mode gates interface, clock out and charge
    always_comb begin
        onBackup                 = ~mainHigher;
        internalSupplyFromBackup = onBackup;
        trickleChargeEnable      = (|chargeResistorSelect) & ~onBackup;
        serialInterfaceEnable    = ~onBackup & aboveLower;
        clockOutputEnable        = ~onBackup & aboveLower;
        interruptOutputEnable    = 1'b1;
    end

    // ----------------------------------------------------------------
    // State and registers
    // ----------------------------------------------------------------
    rps_state_type state_q, state_d;
    logic [CNT_W-1:0] scanCnt_q, scanCnt_d;
    logic [CNT_W-1:0] wdogCnt_q, wdogCnt_d;
    rps_flags_type    flags_q, flags_d;
    logic             srEn_q, srEn_d;
    logic             self_recovery_irq_enable_q, self_recovery_irq_enable_d;
    logic [7:0]       temp_q, temp_d;
    logic             tempValid_q, tempValid_d;
    logic             tempBusy_q, tempBusy_d;
    logic             compBusy_q, compBusy_d;
    logic             tempStart_q, tempStart_d;
    logic             compStart_q, compStart_d;
    logic             reload_q, reload_d;

    logic [CNT_W-1:0] periodCyc;
    logic [CNT_W-1:0] wdogLimit;
    logic             scanTick;
    logic             deadlock;
    logic             sysReset;
    logic             lvFlagsSet;

    // Monitoring period from the period select, deadlock budget from it
    always_comb begin
        periodCyc = thermometerPeriodSelect ? CNT_W'(LONG_CYC)
                                            : CNT_W'(SLOW_CYC);
        wdogLimit = CNT_W'(WDOG_PERIODS) * periodCyc;
        scanTick  = (state_q == RPS_FAST_SCAN) ? (scanCnt_q >= CNT_W'(FAST_CYC - 1))
                                               : (scanCnt_q >= periodCyc - 1'b1);
        deadlock  = srEn_q & (wdogCnt_q >= wdogLimit - 1'b1);
        sysReset  = softwareResetCommand | deadlock;
        lvFlagsSet = flags_q.lowVoltageUpperFlag | flags_q.lowVoltageLowerFlag;
    end

    // Next state of the sequencer and all status
    always_comb begin
        state_d     = state_q;
        scanCnt_d   = scanTick ? '0 : scanCnt_q + 1'b1;
        wdogCnt_d   = controlAlive ? '0 : wdogCnt_q + 1'b1;
        flags_d     = flags_q;
        srEn_d      = srEn_q;
        self_recovery_irq_enable_d      = self_recovery_irq_enable_q;
        temp_d      = temp_q;
        tempValid_d = tempValid_q;
        tempBusy_d  = tempBusy_q;
        compBusy_d  = compBusy_q;
        tempStart_d = 1'b0;
        compStart_d = 1'b0;
        reload_d    = 1'b0;

        // Host clears by writing 0; a write of 1 has no strobe here
        if (flagClear.powerOnFlag)         flags_d.powerOnFlag         = 1'b0;
        if (flagClear.systemResetFlag)     flags_d.systemResetFlag     = 1'b0;
        if (flagClear.selfRecoveryIrqFlag) flags_d.selfRecoveryIrqFlag = 1'b0;
        if (flagClear.lowVoltageUpperFlag) flags_d.lowVoltageUpperFlag = 1'b0;
        if (flagClear.lowVoltageLowerFlag) flags_d.lowVoltageLowerFlag = 1'b0;

        if (setSelfRecoveryEnable) begin
            srEn_d = selfRecoveryEnableValue;
        end
        if (setSelfRecoveryIrqEnable) begin
            self_recovery_irq_enable_d = selfRecoveryIrqEnableValue;
        end

        case (state_q)
            RPS_HOLD: begin
                scanCnt_d = '0;
                if (supplyOk) begin
                    state_d = RPS_LOAD;
                end
            end
            RPS_LOAD: begin
                reload_d            = 1'b1;
                srEn_d              = 1'b1;
                self_recovery_irq_enable_d              = 1'b0;
                flags_d.powerOnFlag = 1'b1;
                state_d             = RPS_WAIT_OSC;
            end
            RPS_WAIT_OSC: begin
                scanCnt_d = '0;
                if (oscOk) begin
                    state_d = RPS_FAST_SCAN;
                end
            end
            RPS_FAST_SCAN: begin
                if (scanTick && aboveLower) begin
                    state_d   = RPS_EE_LOAD;
                    scanCnt_d = '0;
                end
            end
            RPS_EE_LOAD: begin
                scanCnt_d = '0;
                if (eeConfigValid) begin
                    flags_d.lowVoltageUpperFlag = 1'b0;
                    flags_d.lowVoltageLowerFlag = 1'b0;
                    if (thermometerEnable) begin
                        state_d     = RPS_TEMP;
                        tempStart_d = 1'b1;
                        tempBusy_d  = 1'b1;
                    end else begin
                        state_d = RPS_RUN;
                    end
                end
            end
            RPS_TEMP: begin
                // Measure, then compute compensation, then run
                if (tempBusy_q && tempDone) begin
                    temp_d      = tempMeasured;
                    tempValid_d = 1'b1;
                    tempBusy_d  = 1'b0;
                    compBusy_d  = 1'b1;
                    compStart_d = 1'b1;
                end else if (compBusy_q && compDone) begin
                    compBusy_d = 1'b0;
                    state_d    = RPS_RUN;
                end
            end
            RPS_RUN: begin
                // Periodic sampling; flags set on low supply
                if (scanTick) begin
                    if (!aboveUpper) begin
                        flags_d.lowVoltageUpperFlag = 1'b1;
                    end
                    if (!aboveLower) begin
                        flags_d.lowVoltageLowerFlag = 1'b1;
                    end
                    // Thermometer runs only with supply and clear flags
                    if (thermometerEnable && aboveUpper && !lvFlagsSet
                        && !tempBusy_q) begin
                        tempStart_d = 1'b1;
                        tempBusy_d  = 1'b1;
                    end
                end
                if (tempBusy_q && tempDone) begin
                    tempBusy_d = 1'b0;
                    if (aboveUpper) begin
                        temp_d      = tempMeasured;
                        tempValid_d = 1'b1;
                    end
                end
            end
            default: begin
                state_d = RPS_HOLD;
            end
        endcase

        // System reset from software or deadlock reloads the same values
        if (sysReset && (state_q == RPS_RUN)) begin
            reload_d                = 1'b1;
            srEn_d                  = 1'b1;
            self_recovery_irq_enable_d                  = 1'b0;
            flags_d.systemResetFlag = 1'b1;
            wdogCnt_d               = '0;
            if (deadlock) begin
                flags_d.selfRecoveryIrqFlag = 1'b1;
            end
        end

        // Supply lost below the power-on threshold goes back to hold
        if (!supplyOk && (state_q != RPS_HOLD)) begin
            state_d     = RPS_HOLD;
            tempBusy_d  = 1'b0;
            compBusy_d  = 1'b0;
            tempValid_d = 1'b0;
            temp_d      = TEMP_RESET;
        end
    end

    // Register the sequencer state
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q     <= RPS_HOLD;
            scanCnt_q   <= '0;
            wdogCnt_q   <= '0;
            flags_q     <= '0;
            srEn_q      <= 1'b1;
            self_recovery_irq_enable_q      <= 1'b0;
            temp_q      <= TEMP_RESET;
            tempValid_q <= 1'b0;
            tempBusy_q  <= 1'b0;
            compBusy_q  <= 1'b0;
            tempStart_q <= 1'b0;
            compStart_q <= 1'b0;
            reload_q    <= 1'b0;
        end else begin
            state_q     <= state_d;
            scanCnt_q   <= scanCnt_d;
            wdogCnt_q   <= wdogCnt_d;
            flags_q     <= flags_d;
            srEn_q      <= srEn_d;
            self_recovery_irq_enable_q      <= self_recovery_irq_enable_d;
            temp_q      <= temp_d;
            tempValid_q <= tempValid_d;
            tempBusy_q  <= tempBusy_d;
            compBusy_q  <= compBusy_d;
            tempStart_q <= tempStart_d;
            compStart_q <= compStart_d;
            reload_q    <= reload_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic frozen;

    // Uncleared flags freeze the reading at zero when none is valid; that or the lower flag stops compensation
    always_comb begin
        frozen             = lvFlagsSet & ~tempValid_q;
        temperature        = frozen ? TEMP_FROZEN : temp_q;
        compensationActive = (state_q == RPS_RUN) & ~frozen
                             & ~flags_q.lowVoltageLowerFlag;
        fullyFunctional    = (state_q == RPS_RUN);
        eeReadEnable       = (state_q == RPS_EE_LOAD) | (state_q == RPS_TEMP)
                             | (state_q == RPS_RUN);
        fastScanActive     = (state_q == RPS_FAST_SCAN);
        registerReload     = reload_q;
        tempStart          = tempStart_q;
        compStart          = compStart_q;
        flags              = flags_q;
        selfRecoveryEnable    = srEn_q;
        selfRecoveryIrqEnable = self_recovery_irq_enable_q;
        selfRecoveryIrq    = flags_q.selfRecoveryIrqFlag & self_recovery_irq_enable_q;
    end

endmodule : rps_sequencer

`default_nettype wire

//--- hw/rps_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
`default_nettype none

module rps_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage1_d;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage2_d;

    // Next values of both stages
    always_comb begin
        stage1_d = asyncIn;
        stage2_d = stage1_q;
    end

    // Register the stages
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
        end
    end

    assign syncOut = stage2_q;

endmodule : rps_sync

`default_nettype wire

//--- verif/rps_meas_model.sv
// Thermometer and compensation unit answering the sequencer
`timescale 1ns/1ns
`default_nettype none
module rps_meas_model (
    // Clock and pace
    input  wire logic       clk,
    input  wire logic       slow,
    // Requests and reading to report
    input  wire logic       tempStart,
    input  wire logic       compStart,
    input  wire logic [7:0] reading,
    // Answers
    output logic            tempDone = 1'b0,
    output logic [7:0]      tempMeasured = 8'h00,
    output logic            compDone = 1'b0
);
    int tCnt = 0;
    int cCnt = 0;
    // Count each request down; data is valid only with the done pulse
    always @(posedge clk) begin
        tempDone <= (tCnt == 1);
        compDone <= (cCnt == 1);
        tempMeasured <= (tCnt == 1) ? reading : ~tempMeasured;
        tCnt <= tempStart ? (slow ? 20 : 1) : (tCnt > 0 ? tCnt - 1 : 0);
        cCnt <= compStart ? (slow ? 20 : 1) : (cCnt > 0 ? cCnt - 1 : 0);
    end
endmodule : rps_meas_model
`default_nettype wire

//--- verif/rps_sequencer_checker.sv
// Port checker for the power and reset sequencer
`timescale 1ns/1ns
`default_nettype none
module rps_sequencer_checker #(
    parameter int SLOW_CYC = 100,
    parameter int LONG_CYC = 400
) (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   rst,
    // Inputs
    input wire logic                   mainAboveBackup,
    input wire logic [3:0]             chargeResistorSelect,
    input wire logic                   thermometerPeriodSelect,
    input wire logic                   eeConfigValid,
    input wire logic                   softwareResetCommand,
    input wire rps_pkg::rps_clear_type flagClear,
    input wire logic                   controlAlive,
    // Outputs
    input wire logic                   internalSupplyFromBackup,
    input wire logic                   trickleChargeEnable,
    input wire logic                   serialInterfaceEnable,
    input wire logic                   clockOutputEnable,
    input wire logic                   interruptOutputEnable,
    input wire logic                   registerReload,
    input wire logic                   eeReadEnable,
    input wire logic                   fullyFunctional,
    input wire rps_pkg::rps_flags_type flags,
    input wire logic                   selfRecoveryEnable,
    input wire logic                   selfRecoveryIrqEnable,
    input wire logic                   selfRecoveryIrq
);
    import rps_pkg::*;
    logic [31:0] wdCnt_q;
    logic [31:0] wdCnt_d;
    logic [31:0] wdLimit;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Cycles in service without a restart of the deadlock counter
    always_comb begin
        wdCnt_d = wdCnt_q + 32'h1;
        if (controlAlive || registerReload || !fullyFunctional || !selfRecoveryEnable) begin
            wdCnt_d = 32'h0;
        end
    end
    always_ff @(posedge clk) begin
        wdCnt_q <= rst ? 32'h0 : wdCnt_d;
    end
    assign wdLimit = 32'(2 * (thermometerPeriodSelect ? LONG_CYC : SLOW_CYC) + 16);
    trickle_backup_a: assert property (internalSupplyFromBackup |-> !trickleChargeEnable)
        else $error("trickle charge on while on backup");
    trickle_select_a: assert property (trickleChargeEnable |-> chargeResistorSelect != 4'h0)
        else $error("trickle charge on without a resistor");
    supply_select_a: assert property ($stable(mainAboveBackup) [*3]
        ##0 (!$past(rst) && !$past(rst, 2))
        |-> internalSupplyFromBackup == !mainAboveBackup) else $error("wrong supply chosen");
    backup_gating_a: assert property (internalSupplyFromBackup |-> !serialInterfaceEnable
        && !clockOutputEnable && interruptOutputEnable) else $error("backup gating wrong");
    reset_values_a: assert property ($fell(rst) |-> selfRecoveryEnable
        && !selfRecoveryIrqEnable) else $error("recovery enables wrong after reset");
    pon_sticky_a: assert property (flags.powerOnFlag && !flagClear.powerOnFlag
        && !registerReload |=> flags.powerOnFlag) else $error("power-on flag lost");
    sr_sticky_a: assert property (flags.systemResetFlag && !flagClear.systemResetFlag
        && !registerReload |=> flags.systemResetFlag) else $error("reset flag lost");
    sw_reset_a: assert property (softwareResetCommand && fullyFunctional
        |-> ##[1:3] registerReload ##[0:2] flags.systemResetFlag) else $error("no software reset");
    ee_clear_a: assert property ($rose(eeReadEnable) && eeConfigValid |-> ##[1:3]
        (!flags.lowVoltageUpperFlag && !flags.lowVoltageLowerFlag)) else $error("flags not cleared");
    sr_irq_a: assert property (selfRecoveryIrq == (flags.selfRecoveryIrqFlag
        && selfRecoveryIrqEnable)) else $error("recovery interrupt wrong");
    watchdog_bound_a: assert property (wdCnt_q <= wdLimit)
        else $error("self-recovery reset too late");
endmodule : rps_sequencer_checker
bind rps_sequencer rps_sequencer_checker #(.SLOW_CYC(SLOW_CYC), .LONG_CYC(LONG_CYC)) i_chk (.*);
`default_nettype wire

//--- verif/rps_sequencer_tb_top.sv
// Self-checking bench for the power and reset sequencer
`timescale 1ns/1ns
`default_nettype none
module rps_sequencer_tb_top;
    import rps_pkg::*;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0, aliveOn = 1'b1, controlAlive = 1'b0;
    logic mainAboveBackup = 1'b1, supplyAboveThreshold = 1'b1, oscRunning = 1'b1;
    logic aboveLowerThreshold = 1'b1, aboveUpperThreshold = 1'b1, eeConfigValid = 1'b1;
    logic thermometerEnable = 1'b1, thermometerPeriodSelect = 1'b0, softwareResetCommand = 1'b0;
    logic setSelfRecoveryEnable = 1'b0, setSelfRecoveryIrqEnable = 1'b0;
    logic selfRecoveryEnableValue = 1'b0, selfRecoveryIrqEnableValue = 1'b0;
    logic [3:0] chargeResistorSelect = 4'h1;
    logic [7:0] reading = 8'h5A, tempMeasured, temperature;
    logic [15:0] rnd = 16'hB59D;
    rps_clear_type flagClear = 5'h00;
    rps_flags_type flags;
    logic tempDone, compDone, internalSupplyFromBackup, trickleChargeEnable, serialInterfaceEnable;
    logic clockOutputEnable, interruptOutputEnable, registerReload, eeReadEnable, fastScanActive;
    logic tempStart, compStart, compensationActive, fullyFunctional, selfRecoveryEnable;
    logic selfRecoveryIrqEnable, selfRecoveryIrq;
    wire logic [3:0] evt = {fullyFunctional, registerReload, flags[1:0]};
    int nErrors = 0;
    int testsRun = 0;
    int i;
    rps_sequencer #(.SLOW_CYC(100), .LONG_CYC(400), .FAST_CYC(8)) i_dut (.*);
    rps_meas_model i_meas (.clk, .slow, .tempStart, .compStart, .reading, .tempDone,
        .tempMeasured, .compDone);
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // Expected trickle, serial, clock output and interrupt enables
    function automatic logic [7:0] exp_gate(logic onMain, logic [3:0] res);
        return {4'h0, onMain && (res != 4'h0), onMain, onMain, 1'b1};
    endfunction : exp_gate
    task automatic check(string what, logic [7:0] seen, logic [7:0] expected);
        testsRun++;
        if (seen !== expected) begin
            nErrors++;
            $display("FAIL %s expected %h seen %h", what, expected, seen);
        end
    endtask : check
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    // Bounded wait for one of the watched events
    task automatic wait_evt(int k, int n);
        for (int j = 0; j < n; j++) begin
            if (evt[k] === 1'b1) return;
            tick();
        end
        nErrors++;
        $display("FAIL wait for event %0d expired", k);
        wrap_up();
    endtask : wait_evt
    task automatic clear_flags(logic [4:0] v);
        flagClear = v;
        tick();
        flagClear = 5'h00;
        tick();
    endtask : clear_flags
    // Clock and the control logic keeping the deadlock counter alive
    initial forever #25 clk = ~clk;
    always begin
        tick(10);
        controlAlive = aliveOn;
        tick();
        controlAlive = 1'b0;
    end
    initial begin
        tick(6);
        rst = 1'b0;
        check("flags after reset", 8'(flags), 8'h00);
        wait_evt(3, 400);
        check("flags after power-up", 8'(flags), 8'h10);
        check("temperature", temperature, reading);
        check("recovery enables", 8'({selfRecoveryEnable, selfRecoveryIrqEnable}), 8'h02);
        clear_flags(5'h10);
        check("power-on cleared", 8'(flags), 8'h00);
        $display("power-up test done");
        for (i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            mainAboveBackup = (i == 0) | rnd[0];
            chargeResistorSelect = (i == 0) ? 4'h0 : rnd[4:1];
            slow = rnd[5];
            tick(4);
            check("supply source", 8'(internalSupplyFromBackup), 8'(!mainAboveBackup));
            check("gates", 8'({trickleChargeEnable, serialInterfaceEnable, clockOutputEnable,
                interruptOutputEnable}), exp_gate(mainAboveBackup, chargeResistorSelect));
        end
        mainAboveBackup = 1'b1;
        $display("supply test done");
        aboveUpperThreshold = 1'b0;
        wait_evt(1, 320);
        check("held temperature", temperature, reading);
        check("compensation kept", 8'(compensationActive), 8'h01);
        aboveLowerThreshold = 1'b0;
        wait_evt(0, 320);
        tick(3);
        check("serial off", 8'(serialInterfaceEnable), 8'h00);
        aboveLowerThreshold = 1'b1;
        aboveUpperThreshold = 1'b1;
        tick(4);
        clear_flags(5'h03);
        check("low flags cleared", 8'(flags), 8'h00);
        $display("low voltage test done");
        {setSelfRecoveryEnable, setSelfRecoveryIrqEnable, selfRecoveryIrqEnableValue} = 3'h7;
        tick();
        {setSelfRecoveryEnable, setSelfRecoveryIrqEnable} = 2'h0;
        softwareResetCommand = 1'b1;
        tick();
        softwareResetCommand = 1'b0;
        wait_evt(2, 5);
        wait_evt(3, 400);
        check("flags after command", 8'(flags), 8'h08);
        check("enables after command", 8'({selfRecoveryEnable, selfRecoveryIrqEnable}), 8'h02);
        clear_flags(5'h08);
        $display("software reset test done");
        setSelfRecoveryIrqEnable = 1'b1;
        tick();
        setSelfRecoveryIrqEnable = 1'b0;
        aliveOn = 1'b0;
        wait_evt(2, 220);
        aliveOn = 1'b1;
        wait_evt(3, 400);
        check("flags after recovery", 8'(flags), 8'h0C);
        check("enables after recovery", 8'({selfRecoveryEnable, selfRecoveryIrqEnable}), 8'h02);
        check("interrupt masked", 8'(selfRecoveryIrq), 8'h00);
        setSelfRecoveryIrqEnable = 1'b1;
        tick();
        setSelfRecoveryIrqEnable = 1'b0;
        check("interrupt raised", 8'(selfRecoveryIrq), 8'h01);
        clear_flags(5'h04);
        check("interrupt cleared", 8'(selfRecoveryIrq), 8'h00);
        $display("self-recovery test done");
        wrap_up();
    end
endmodule : rps_sequencer_tb_top
`default_nettype wire
